// ### verilog/cic_top.v
// cascaded interrupt controller pair with pci acknowledge conversion and steering
`timescale 1ns/1ps
//
// Function
// - master serves lines 0-7, slave serves lines 8-15
// - slave output feeds master input 2; no external line 2
// - master input 0 comes from timer counter 0 output
// - slave line 13 comes from fpu error input
// - each line selectable edge or level detection
// - four pci lines steerable to 3-7, 9-12, 14 or 15
// - controllers initialized separately; defaults edge, normal eoi, cascade on
// - mouse bit set makes line 12 come from mouse source
// - line 15 has no pin; serial and pci sources may drive it
// - active request sets its request latch bit
// - latched unmasked higher-priority request raises cpu request
// - one pci acknowledge makes two internal acknowledge pulses
// - acknowledge sequence completes in minimum cycles
// - first pulse sets top in-service bit, clears latch, no drive
// - master broadcasts 3-bit cascade code after first pulse
// - second pulse releases 8-bit vector to complete pci acknowledge
// - auto eoi clears in-service after second pulse, else eoi command
// - no request at acknowledge yields level 7
// - first pulse freezes state for stable priority resolution
// - vector is base bits 7-3 and line number bits 2-0
// - priority 0,1, slave 8-15, then master 3-7
// - slave answers only if cascade code matches its id bits
// - init bit write starts init; three mask-port writes follow
// - mask word bit one masks its line
// - non-specific eoi clears lowest-numbered set in-service bit
module cic_top (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire [7:0] i_io_addr,
  input wire [7:0] i_io_wdata,
  output reg [7:0] o_io_rdata,
  input wire i_pci_int_ack_pulse,
  output reg o_int_ack_pulse_done,
  output reg [7:0] o_int_ack_pulse_vector,
  output reg o_cpu_int_request,
  input wire [15:0] i_irq_pins,
  input wire [3:0] i_pci_int_lines_n,
  input wire [15:0] i_serial_irq_stream,
  input wire i_timer0_out,
  input wire i_fpu_error_in_n,
  input wire i_mouse_irq_line,
  input wire [7:0] i_xbus_chip_select_cfg,
  input wire [15:0] i_edge_level_cfg,
  input wire [15:0] i_pci_steer_cfg
);
`include "cic_regs.vh"

// ************
// functions
// ************
  // lowest set bit index, no rotation so bit 0 wins; 8 when none set
  function [3:0] cic_top_bit;
    input [7:0] v;
    integer k;
    begin
      cic_top_bit = 4'h8;
      for (k = 7; k >= 0; k = k - 1) begin
        if (v[k]) begin
          cic_top_bit = k[3:0];
        end
      end
    end
  endfunction

  function cic_steer_ok;
    input [3:0] n;
    begin
      cic_steer_ok = (n >= 4'h3 && n <= 4'h7) || (n >= 4'h9 && n <= 4'hc) || n == 4'he || n == 4'hf;
    end
  endfunction

// ************
// input synchronisers
// ************
  reg [15:0] pin_s1_reg, pin_s2_reg, ser_s1_reg, ser_s2_reg;
  reg [3:0] pci_s1_reg, pci_s2_reg;
  reg [2:0] misc_s1_reg, misc_s2_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_reg <= 16'h0000;
      pin_s2_reg <= 16'h0000;
      ser_s1_reg <= 16'h0000;
      ser_s2_reg <= 16'h0000;
      pci_s1_reg <= 4'hf;
      pci_s2_reg <= 4'hf;
      misc_s1_reg <= 3'h2;
      misc_s2_reg <= 3'h2;
    end else begin
      pin_s1_reg <= i_irq_pins;
      pin_s2_reg <= pin_s1_reg;
      ser_s1_reg <= i_serial_irq_stream;
      ser_s2_reg <= ser_s1_reg;
      pci_s1_reg <= i_pci_int_lines_n;
      pci_s2_reg <= pci_s1_reg;
      misc_s1_reg <= {i_mouse_irq_line, i_fpu_error_in_n, i_timer0_out};
      misc_s2_reg <= misc_s1_reg;
    end
  end

// ************
// request line assembly
// ************
  reg [15:0] raw_req;
  integer p;
  always @* begin
    raw_req = pin_s2_reg | ser_s2_reg;
    raw_req[15] = ser_s2_reg[15];
    raw_req[8] = pin_s2_reg[8];
    if (i_xbus_chip_select_cfg[`CIC_MOUSE_BIT]) begin
      raw_req[12] = misc_s2_reg[2] | ser_s2_reg[12];
    end
    for (p = 0; p < 4; p = p + 1) begin
      if (!pci_s2_reg[p] && cic_steer_ok(i_pci_steer_cfg[p*4 +: 4])) begin
        raw_req[i_pci_steer_cfg[p*4 +: 4]] = 1'b1;
      end
    end
    raw_req[0] = misc_s2_reg[0];
    raw_req[13] = ~misc_s2_reg[1];
    raw_req[2] = 1'b0;
  end

// ************
// controller state, index 0 master, 1 slave
// ************
  reg [7:0] irr_reg [0:1];
  reg [7:0] isr_reg [0:1];
  reg [7:0] imr_reg [0:1];
  reg [7:0] prev_reg [0:1];
  reg [4:0] base_reg [0:1];
  reg [7:0] casc_id_reg [0:1];
  reg [1:0] init_step_reg [0:1];
  reg auto_eoi_mode_reg [0:1];
  reg level_mode_reg [0:1];
  reg read_isr_reg [0:1];
  reg slave_int_reg;
  reg [15:0] line_in;
  always @* begin
    line_in = raw_req;
    line_in[2] = slave_int_reg;
  end

// ************
// request events
// ************
  // request event per line, one cycle on edge lines, the level itself on level lines; an event landing in the acknowledge
  // cycle must not be lost to the latch clear, so the set wins
  reg [15:0] set_req;
  integer q;
  always @* begin
    set_req = 16'h0000;
    for (q = 0; q < 16; q = q + 1) begin
      if (level_mode_reg[q / 8] || i_edge_level_cfg[q]) begin
        set_req[q] = line_in[q];
      end else begin
        set_req[q] = line_in[q] && !prev_reg[q / 8][q % 8];
      end
    end
  end

  // acknowledge sequencer
  localparam ST_IDLE = 3'h0;
  localparam ST_P1 = 3'h1;
  localparam ST_GAP = 3'h2;
  localparam ST_P2 = 3'h3;
  localparam ST_DONE = 3'h4;
  reg [2:0] state_reg;
  reg [1:0] cnt_reg;
  reg [2:0] casc_bus_reg;
  reg [2:0] m_line_reg, s_line_reg;
  reg m_valid_reg, s_valid_reg;

  // master and slave priority, cascade input in master line 2's slot
  wire [7:0] m_pend = irr_reg[0] & ~imr_reg[0];
  wire [7:0] s_pend = irr_reg[1] & ~imr_reg[1];
  wire [3:0] m_top = cic_top_bit(m_pend);
  wire [3:0] s_top = cic_top_bit(s_pend);
  wire [3:0] m_isr_top = cic_top_bit(isr_reg[0]);
  wire [3:0] s_isr_top = cic_top_bit(isr_reg[1]);
  wire m_qual = !m_top[3] && (m_isr_top[3] || m_top < m_isr_top);
  wire s_qual = !s_top[3] && (s_isr_top[3] || s_top < s_isr_top);

  integer c, b;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (c = 0; c < 2; c = c + 1) begin
        irr_reg[c] <= 8'h00;
        isr_reg[c] <= 8'h00;
        imr_reg[c] <= 8'h00;
        prev_reg[c] <= 8'h00;
        base_reg[c] <= 5'h00;
        casc_id_reg[c] <= 8'h00;
        init_step_reg[c] <= 2'h0;
        auto_eoi_mode_reg[c] <= 1'b0;
        level_mode_reg[c] <= 1'b0;
        read_isr_reg[c] <= 1'b0;
      end
      slave_int_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      casc_bus_reg <= 3'h0;
      m_line_reg <= 3'h0;
      s_line_reg <= 3'h0;
      m_valid_reg <= 1'b0;
      s_valid_reg <= 1'b0;
      o_int_ack_pulse_done <= 1'b0;
      o_int_ack_pulse_vector <= 8'h00;
      o_cpu_int_request <= 1'b0;
      o_io_rdata <= 8'h00;
    end else begin
      o_int_ack_pulse_done <= 1'b0;
      slave_int_reg <= s_qual;
      o_cpu_int_request <= m_qual && state_reg == ST_IDLE;
      for (c = 0; c < 2; c = c + 1) begin
        prev_reg[c] <= line_in[c*8 +: 8];
        for (b = 0; b < 8; b = b + 1) begin
          if (level_mode_reg[c] || i_edge_level_cfg[c*8+b]) begin
            if (line_in[c*8+b]) irr_reg[c][b] <= 1'b1;
            else if (state_reg == ST_IDLE) irr_reg[c][b] <= 1'b0;
          end else if (line_in[c*8+b] && !prev_reg[c][b]) begin
            irr_reg[c][b] <= 1'b1;
          end else if (!line_in[c*8+b] && state_reg == ST_IDLE) begin
            irr_reg[c][b] <= 1'b0; // withdrawn request drops, giving level 7 later
          end
        end
      end
      // cascade slot follows slave output except in a master init write cycle
      irr_reg[0][2] <= slave_int_reg;
      case (state_reg)
        ST_IDLE: begin
          if (i_pci_int_ack_pulse) begin
            state_reg <= ST_P1;
            cnt_reg <= 2'h0;
          end
        end
        ST_P1: begin
          // snapshot taken once; requests keep latching but winner is fixed
          if (cnt_reg == 2'h0) begin
            m_valid_reg <= !m_top[3];
            m_line_reg <= m_top[3] ? `CIC_SPURIOUS_LINE : m_top[2:0];
            s_valid_reg <= !s_top[3];
            s_line_reg <= s_top[3] ? `CIC_SPURIOUS_LINE : s_top[2:0];
            if (!m_top[3]) begin
              isr_reg[0][m_top[2:0]] <= 1'b1;
              if (m_top[2:0] != `CIC_CASCADE_IN && !set_req[{1'b0, m_top[2:0]}]) begin
                irr_reg[0][m_top[2:0]] <= 1'b0;
              end
              if (m_top[2:0] == `CIC_CASCADE_IN && !s_top[3]) begin
                isr_reg[1][s_top[2:0]] <= 1'b1;
                if (!set_req[{1'b1, s_top[2:0]}]) irr_reg[1][s_top[2:0]] <= 1'b0;
              end
            end
          end
          if (cnt_reg == `CIC_ACK_PULSE_CYC - 1) begin
            // code from the frozen winner, not the live latch
            casc_bus_reg <= m_valid_reg ? m_line_reg : 3'h0;
            state_reg <= ST_GAP;
          end
          cnt_reg <= cnt_reg + 2'h1;
        end
        ST_GAP: begin
          state_reg <= ST_P2;
        end
        ST_P2: begin
          if (m_valid_reg && m_line_reg == `CIC_CASCADE_IN) begin
            // master off the bus; slave drives only on id match
            if (casc_bus_reg == casc_id_reg[1][2:0]) begin
              o_int_ack_pulse_vector <= {base_reg[1], s_line_reg};
              if (auto_eoi_mode_reg[1] && s_valid_reg) isr_reg[1][s_line_reg] <= 1'b0;
            end else begin
              o_int_ack_pulse_vector <= 8'h00;
            end
          end else begin
            o_int_ack_pulse_vector <= {base_reg[0], m_line_reg};
          end
          if (auto_eoi_mode_reg[0] && m_valid_reg) isr_reg[0][m_line_reg] <= 1'b0;
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          o_int_ack_pulse_done <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // port writes; assigned last, so they take priority over acknowledge effects above on same bit
      for (c = 0; c < 2; c = c + 1) begin
        if (i_io_wr && i_io_addr == (c == 0 ? `CIC_MASTER_CMD_PORT : `CIC_SLAVE_CMD_PORT)) begin
          if (i_io_wdata[`CIC_INIT_BIT]) begin
            init_step_reg[c] <= 2'h1;
            imr_reg[c] <= 8'h00;
            isr_reg[c] <= 8'h00;
            irr_reg[c] <= 8'h00;
            prev_reg[c] <= 8'hff; // fresh low-to-high edge needed after init
            level_mode_reg[c] <= i_io_wdata[`CIC_LTIM_BIT];
            read_isr_reg[c] <= 1'b0;
            auto_eoi_mode_reg[c] <= 1'b0;
            casc_id_reg[c] <= 8'h07;
          end else if (i_io_wdata[`CIC_OCW3_BIT]) begin
            if (i_io_wdata[`CIC_RR_BIT]) read_isr_reg[c] <= i_io_wdata[`CIC_RIS_BIT];
          end else if (i_io_wdata[`CIC_EOI_BIT]) begin
            if (i_io_wdata[`CIC_SL_BIT]) isr_reg[c][i_io_wdata[2:0]] <= 1'b0;
            else if (c == 0 && !m_isr_top[3]) isr_reg[0][m_isr_top[2:0]] <= 1'b0;
            else if (c == 1 && !s_isr_top[3]) isr_reg[1][s_isr_top[2:0]] <= 1'b0;
          end
        end
        if (i_io_wr && i_io_addr == (c == 0 ? `CIC_MASTER_MASK_PORT : `CIC_SLAVE_MASK_PORT)) begin
          case (init_step_reg[c])
            2'h1: begin
              base_reg[c] <= i_io_wdata[7:3];
              init_step_reg[c] <= 2'h2;
            end
            2'h2: begin
              casc_id_reg[c] <= i_io_wdata;
              init_step_reg[c] <= 2'h3;
            end
            2'h3: begin
              auto_eoi_mode_reg[c] <= i_io_wdata[`CIC_AUTO_EOI_MODE_BIT];
              init_step_reg[c] <= 2'h0;
            end
            default: begin
              imr_reg[c] <= i_io_wdata;
            end
          endcase
        end
      end
      // reads
      if (i_io_rd) begin
        case (i_io_addr)
          `CIC_MASTER_CMD_PORT: o_io_rdata <= read_isr_reg[0] ? isr_reg[0] : irr_reg[0];
          `CIC_MASTER_MASK_PORT: o_io_rdata <= imr_reg[0];
          `CIC_SLAVE_CMD_PORT: o_io_rdata <= read_isr_reg[1] ? isr_reg[1] : irr_reg[1];
          `CIC_SLAVE_MASK_PORT: o_io_rdata <= imr_reg[1];
          default: o_io_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // cic_top

// ### verilog/cic_regs.vh
// register offsets, field positions and timing counts for the cascaded interrupt controller
`ifndef CIC_REGS_VH
`define CIC_REGS_VH
`define CIC_MASTER_CMD_PORT 8'h20
`define CIC_MASTER_MASK_PORT 8'h21
`define CIC_SLAVE_CMD_PORT 8'ha0
`define CIC_SLAVE_MASK_PORT 8'ha1
`define CIC_INIT_BIT 4
`define CIC_LTIM_BIT 3
`define CIC_EOI_BIT 5
`define CIC_SL_BIT 6
`define CIC_AUTO_EOI_MODE_BIT 1
`define CIC_OCW3_BIT 3
`define CIC_RR_BIT 1
`define CIC_RIS_BIT 0
`define CIC_CASCADE_IN 3'h2
`define CIC_SPURIOUS_LINE 3'h7
`define CIC_MOUSE_BIT 4
`define CIC_STEER_OFF 4'h0
`define CIC_ACK_PULSE_CYC 2
`define CIC_ACK_GAP_CYC 1
`endif

// ### verif/cic_top_monitor.sv
// port checker for the cascaded interrupt controller
`timescale 1ns/1ps
module cic_top_monitor (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_io_rd,
  input wire [7:0] o_io_rdata,
  input wire i_pci_int_ack_pulse,
  input wire o_int_ack_pulse_done,
  input wire [7:0] o_int_ack_pulse_vector,
  input wire o_cpu_int_request
);
  // ******************
  // acknowledge and read data timing
  // ******************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_pci_int_ack_pulse;
  endsequence
  sequence s_answer;
    ##6 o_int_ack_pulse_done ##1 !o_int_ack_pulse_done;
  endsequence
  a_ack_answer: assert property (s_take |-> s_answer) else $error("ack not answered");
  a_done_cause: assert property (o_int_ack_pulse_done |-> $past(i_pci_int_ack_pulse, 6)) else $error("done without ack");
  a_done_single: assert property (o_int_ack_pulse_done |=> !o_int_ack_pulse_done) else $error("done too long");
  a_vec_lead: assert property ($changed(o_int_ack_pulse_vector) |-> ##1 o_int_ack_pulse_done) else $error("vector early");
  a_vec_cause: assert property ($changed(o_int_ack_pulse_vector) |-> $past(i_pci_int_ack_pulse, 5)) else $error("vector moved");
  a_vec_hold: assert property (o_int_ack_pulse_done |=> $stable(o_int_ack_pulse_vector) [*4]) else $error("vector unstable");
  a_req_frozen: assert property (s_take |-> ##2 !o_cpu_int_request [*3]) else $error("request during ack");
  a_rdata_cause: assert property ($changed(o_io_rdata) |-> $past(i_io_rd)) else $error("read data moved");
endmodule // cic_top_monitor
bind cic_top cic_top_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_rd(i_io_rd),
  .o_io_rdata(o_io_rdata), .i_pci_int_ack_pulse(i_pci_int_ack_pulse), .o_int_ack_pulse_done(o_int_ack_pulse_done),
  .o_int_ack_pulse_vector(o_int_ack_pulse_vector), .o_cpu_int_request(o_cpu_int_request));

// ### verif/cic_host_model.sv
// host bridge model issuing pci acknowledge cycles
`timescale 1ns/1ps
module cic_host_model (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire [3:0] i_delay,
  input wire i_int_ack_pulse_done,
  input wire [7:0] i_int_ack_pulse_vector,
  output reg o_pci_int_ack_pulse,
  output reg o_got,
  output reg [7:0] o_vector
);
  // ********************
  // acknowledge sequence
  // ********************
  reg [3:0] wait_reg;
  reg armed_reg;
  reg busy_reg;
  // a slow bridge waits i_delay cycles before the single cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pci_int_ack_pulse <= 1'b0;
      o_got <= 1'b0;
      o_vector <= 8'h00;
      wait_reg <= 4'h0;
      armed_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      o_pci_int_ack_pulse <= 1'b0;
      o_got <= 1'b0;
      if (i_start && !busy_reg) begin
        busy_reg <= 1'b1;
        armed_reg <= 1'b1;
        wait_reg <= i_delay;
      end else if (armed_reg) begin
        if (wait_reg == 4'h0) begin
          o_pci_int_ack_pulse <= 1'b1;
          armed_reg <= 1'b0;
        end else begin
          wait_reg <= wait_reg - 4'h1;
        end
      end else if (busy_reg && i_int_ack_pulse_done) begin
        busy_reg <= 1'b0;
        o_got <= 1'b1;
        o_vector <= i_int_ack_pulse_vector;
      end
    end
  end
endmodule // cic_host_model

// ### verif/tb_top.sv
// self-checking bench for the cascaded interrupt controller
`timescale 1ns/1ps
module tb_top;
  reg i_clk, i_rst_n, i_io_wr, i_io_rd, i_timer0_out, i_fpu_error_in_n, i_mouse_irq_line, start;
  reg [7:0] i_io_addr, i_io_wdata, i_xbus_chip_select_cfg;
  reg [15:0] i_irq_pins, i_serial_irq_stream, i_edge_level_cfg, i_pci_steer_cfg;
  reg [3:0] i_pci_int_lines_n, delay;
  wire [7:0] o_io_rdata, o_int_ack_pulse_vector, host_vec;
  wire o_int_ack_pulse_done, o_cpu_int_request, i_pci_int_ack_pulse, host_got;
  integer n_fail, tests_run, i;
  cic_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_pci_int_ack_pulse(i_pci_int_ack_pulse),
    .o_int_ack_pulse_done(o_int_ack_pulse_done), .o_int_ack_pulse_vector(o_int_ack_pulse_vector), .o_cpu_int_request(o_cpu_int_request),
    .i_irq_pins(i_irq_pins), .i_pci_int_lines_n(i_pci_int_lines_n), .i_serial_irq_stream(i_serial_irq_stream),
    .i_timer0_out(i_timer0_out), .i_fpu_error_in_n(i_fpu_error_in_n), .i_mouse_irq_line(i_mouse_irq_line),
    .i_xbus_chip_select_cfg(i_xbus_chip_select_cfg), .i_edge_level_cfg(i_edge_level_cfg),
    .i_pci_steer_cfg(i_pci_steer_cfg));
  cic_host_model u_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start), .i_delay(delay),
    .i_int_ack_pulse_done(o_int_ack_pulse_done), .i_int_ack_pulse_vector(o_int_ack_pulse_vector), .o_pci_int_ack_pulse(i_pci_int_ack_pulse),
    .o_got(host_got), .o_vector(host_vec));
  // ***********
  // bench tasks
  // ***********
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task io_wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_io_wr <= 1'b1;
      i_io_addr <= a;
      i_io_wdata <= d;
      @(posedge i_clk);
      i_io_wr <= 1'b0;
    end
  endtask
  task io_rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge i_clk);
      i_io_rd <= 1'b1;
      i_io_addr <= a;
      @(posedge i_clk);
      i_io_rd <= 1'b0;
      @(posedge i_clk);
      #1 chk(o_io_rdata, exp);
    end
  endtask
  task ack(input [7:0] exp, input [3:0] d);
    integer k;
    begin
      @(posedge i_clk);
      start <= 1'b1;
      delay <= d;
      @(posedge i_clk);
      start <= 1'b0;
      k = 0;
      while (host_got !== 1'b1 && k < 40) begin
        @(posedge i_clk);
        #1 k = k + 1;
      end
      if (host_got !== 1'b1) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t acknowledge not answered", $time);
      end
      chk(host_vec, exp);
    end
  endtask
  task src(input integer k, input on);
    case (k)
      0: i_irq_pins[3] <= on;
      1: i_timer0_out <= on;
      2: i_fpu_error_in_n <= !on;
      3: i_mouse_irq_line <= on;
      4: i_pci_int_lines_n[0] <= !on;
      default: i_serial_irq_stream[15] <= on;
    endcase
  endtask
  // one source raised, acknowledged, dropped and retired by eoi
  task fire(input integer k, input [7:0] exp);
    begin
      @(posedge i_clk);
      src(k, 1'b1);
      repeat (8) @(posedge i_clk);
      #1 chk({7'h0, o_cpu_int_request}, 8'h01);
      ack(exp, k[3:0]);
      if (exp[6]) io_rd(8'h20, 8'h04);
      io_rd(exp[6] ? 8'ha0 : 8'h20, 8'h01 << exp[2:0]);
      @(posedge i_clk);
      src(k, 1'b0);
      if (exp[6]) io_wr(8'ha0, 8'h20);
      io_wr(8'h20, 8'h20);
      io_rd(8'ha0, 8'h00);
      io_rd(8'h20, 8'h00);
      repeat (4) @(posedge i_clk);
      #1 chk({7'h0, o_cpu_int_request}, 8'h00);
    end
  endtask
  // slave line 10 beats master line 5, then line 5 follows
  task cascade_case;
    begin
      @(posedge i_clk);
      i_irq_pins <= 16'h0420;
      repeat (8) @(posedge i_clk);
      ack(8'h72, 4'h0);
      io_wr(8'ha0, 8'h20);
      io_wr(8'h20, 8'h20);
      ack(8'h0d, 4'h3);
      io_wr(8'h20, 8'h20);
      i_irq_pins <= 16'h0000;
    end
  endtask
  // masked line latches but does not ask until unmasked
  task mask_case;
    begin
      io_wr(8'h21, 8'h10);
      io_rd(8'h21, 8'h10);
      io_rd(8'h30, 8'h00);
      i_irq_pins <= 16'h0010;
      repeat (8) @(posedge i_clk);
      #1 chk({7'h0, o_cpu_int_request}, 8'h00);
      io_wr(8'h21, 8'h00);
      ack(8'h0c, 4'h1);
      io_wr(8'h20, 8'h20);
      i_irq_pins <= 16'h0000;
    end
  endtask
  // request withdrawn before the acknowledge gives level 7
  task spurious_case;
    begin
      @(posedge i_clk);
      i_irq_pins <= 16'h0040;
      repeat (8) @(posedge i_clk);
      i_irq_pins <= 16'h0000;
      repeat (8) @(posedge i_clk);
      ack(8'h0f, 4'h0);
      io_rd(8'h20, 8'h00);
    end
  endtask
  // level line stays latched while held, so it asks again after eoi
  task level_case;
    begin
      @(posedge i_clk);
      i_edge_level_cfg <= 16'h0040;
      i_irq_pins <= 16'h0040;
      repeat (8) @(posedge i_clk);
      ack(8'h0e, 4'h2);
      io_wr(8'h20, 8'h66);
      repeat (4) @(posedge i_clk);
      #1 chk({7'h0, o_cpu_int_request}, 8'h01);
      @(posedge i_clk);
      i_irq_pins <= 16'h0000;
      i_edge_level_cfg <= 16'h0000;
      repeat (6) @(posedge i_clk);
      #1 chk({7'h0, o_cpu_int_request}, 8'h00);
    end
  endtask
  // with the mouse bit clear, line 12 is an ordinary pin
  task mouse_off_case;
    begin
      @(posedge i_clk);
      i_xbus_chip_select_cfg <= 8'h00;
      i_mouse_irq_line <= 1'b1;
      repeat (8) @(posedge i_clk);
      #1 chk({7'h0, o_cpu_int_request}, 8'h00);
      @(posedge i_clk);
      i_mouse_irq_line <= 1'b0;
      i_irq_pins <= 16'h1000;
      repeat (8) @(posedge i_clk);
      ack(8'h74, 4'h0);
      io_wr(8'ha0, 8'h20);
      io_wr(8'h20, 8'h20);
      i_irq_pins <= 16'h0000;
      i_xbus_chip_select_cfg <= 8'h10;
    end
  endtask
  // master re-initialised with auto eoi; in-service clears with no command
  task auto_eoi_mode_case;
    begin
      io_wr(8'h20, 8'h11);
      io_wr(8'h21, 8'h08);
      io_wr(8'h21, 8'h04);
      io_wr(8'h21, 8'h03);
      io_wr(8'h20, 8'h0b);
      @(posedge i_clk);
      i_irq_pins <= 16'h0008;
      repeat (8) @(posedge i_clk);
      ack(8'h0b, 4'h0);
      io_rd(8'h20, 8'h00);
      @(posedge i_clk);
      i_irq_pins <= 16'h0000;
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    $display("MISMATCH t=%0t watchdog", $time);
    stop_test;
  end
  initial begin
    {i_rst_n, i_io_wr, i_io_rd, i_timer0_out, i_mouse_irq_line, start} = 6'h00;
    i_fpu_error_in_n = 1'b1;
    {i_io_addr, i_io_wdata, delay, i_irq_pins, i_serial_irq_stream, i_edge_level_cfg} = 68'h0;
    i_xbus_chip_select_cfg = 8'h10;
    i_pci_steer_cfg = 16'h000f;
    i_pci_int_lines_n = 4'hf;
    n_fail = 0;
    tests_run = 0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      io_wr(i ? 8'h20 : 8'ha0, 8'h11);
      io_wr(i ? 8'h21 : 8'ha1, i ? 8'h08 : 8'h70);
      io_wr(i ? 8'h21 : 8'ha1, i ? 8'h04 : 8'h02);
      io_wr(i ? 8'h21 : 8'ha1, 8'h01);
      io_wr(i ? 8'h21 : 8'ha1, 8'h00);
      io_wr(i ? 8'h20 : 8'ha0, 8'h0b);
    end
    io_rd(8'h21, 8'h00);
    fire(0, 8'h0b);
    fire(1, 8'h08);
    fire(2, 8'h75);
    fire(3, 8'h74);
    fire(4, 8'h77);
    fire(5, 8'h77);
    cascade_case;
    mask_case;
    spurious_case;
    level_case;
    mouse_off_case;
    auto_eoi_mode_case;
    stop_test;
  end
endmodule // tb_top
